// *** hw/ear_encoder.sv ***
// Encoder end: reset/shut-down, set position and access level resources.
// Assumes the master keeps its own obligations and save_done answers save_req.
`timescale 1ns/1ps
module ear_encoder
(
    input wire logic ref_clk,
    input wire logic rstn,
    ear_if.enc lnk,
    input wire logic [ear_pkg::POS_W-1:0] raw_pos,
    input wire logic save_done,
    output logic save_req_ff,
    output logic pos_preset_ff,
    output logic [ear_pkg::POS_W-1:0] pos_offset_ff,
    output logic proto_reset_ff,
    output logic shut_down_ff,
    output logic [2:0] access_level_ff
);
    import ear_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_SAVE = 2'b10,
        ST_DEAD = 2'b11
    } ear_enc_st_t;

    ear_enc_st_t state_ff, nxt_state;
    logic [7:0] buf_ff [0:7];
    logic [7:0] addh_ff, addl_ff, offh_ff, offl_ff, rdata_ff;
    logic rel_ff, err_ff, shut_sel_ff;

    // Decode of the loaded transaction
    wire [9:0] res_idx = {addh_ff[1:0], addl_ff};
    wire is_rd = addh_ff[ADDH_RD_BIT];
    wire is_ind = addh_ff[ADDH_IND_BIT];
    wire [15:0] offset = {offh_ff, offl_ff};
    wire [POS_W-1:0] pos_val = {buf_ff[4], buf_ff[3], buf_ff[2], buf_ff[1], buf_ff[0]};
    wire [31:0] key = {buf_ff[7], buf_ff[6], buf_ff[5], buf_ff[4]};
    wire [7:0] req_lvl = buf_ff[0];
    wire is_reset = res_idx == RES_RESET;
    wire is_pos = res_idx == RES_SHAFT_POSITION_PRESET;
    wire is_acc = res_idx == RES_ACCESS;
    wire known = is_reset | is_pos | is_acc;

    wire [7:0] d_rst = offset == DSC_SIZE ? RST_SIZE : offset == DSC_RDLVL ? RST_RDLVL :
        offset == DSC_WRLVL ? RST_WRLVL : offset == DSC_OVR ? RST_OVR :
        offset == DSC_TYPE ? RST_TYPE : 8'h00;
    wire [7:0] d_pos = offset == DSC_SIZE ? POS_SIZE : offset == DSC_RDLVL ? POS_RDLVL :
        offset == DSC_WRLVL ? POS_WRLVL : offset == DSC_OVR ? POS_OVR :
        offset == DSC_TYPE ? POS_TYPE : 8'h00;
    wire [7:0] d_acc = offset == DSC_SIZE ? ACC_SIZE : offset == DSC_RDLVL ? ACC_RDLVL :
        offset == DSC_WRLVL ? ACC_WRLVL : offset == DSC_OVR ? ACC_OVR :
        offset == DSC_TYPE ? ACC_TYPE : 8'h00;
    wire [7:0] desc = is_reset ? d_rst : is_pos ? d_pos : d_acc;

    // Level needed for the indirect access
    wire [7:0] need_rd = is_reset ? RST_RDLVL : is_pos ? POS_RDLVL : ACC_RDLVL;
    wire [7:0] need_wr = is_reset ? RST_WRLVL : is_pos ? POS_WRLVL : ACC_WRLVL;
    wire [7:0] need = is_rd ? need_rd : need_wr;
    wire refuse = !known | (is_ind & ({5'h00, access_level_ff} < need));

    // Default key is the level digit repeated
    wire [7:0] key_digit = KEY_DIGIT0 + req_lvl;
    wire key_ok = (req_lvl == 8'h00) | (key == {4{key_digit}});
    // Offset must be zero for the access resource
    wire acc_ok = key_ok & (req_lvl <= LVL_MAX) & (offset == 16'h0000);

    wire exec = state_ff == ST_EXEC;
    wire ok_ind = exec & !refuse & is_ind;
    wire do_save = ok_ind & !is_rd & is_reset;
    wire do_pos = ok_ind & !is_rd & is_pos;
    wire do_acc = ok_ind & !is_rd & is_acc & acc_ok;
    wire acc_bad = ok_ind & !is_rd & is_acc & !acc_ok;
    wire bad_sel = do_save & (offset != OFF_RESET) & (offset != OFF_SHUT);
    // Save done for a reset: restart like power-on but keep the position offset
    wire soft_rst = (state_ff == ST_SAVE) & save_done & !shut_sel_ff;
    wire clr = !rstn | soft_rst;
    wire host_wr = (state_ff == ST_IDLE) & lnk.wr;
    wire start = host_wr & (lnk.addr == REG_CTRL) & (lnk.wdata == CTRL_START);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start) begin
                    nxt_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                nxt_state = (do_save & !bad_sel) ? ST_SAVE : ST_IDLE;
            end
            ST_SAVE: begin
                if (save_done) begin
                    nxt_state = shut_sel_ff ? ST_DEAD : ST_IDLE;
                end
            end
            ST_DEAD: begin
                nxt_state = ST_DEAD;
            end
        endcase
    end

    // Result written back into the payload buffer
    logic [7:0] res_byte [0:7];
    // Zero-extended so the byte slices never run past bit 63
    wire [63:0] pos_ext = {24'h000000, pos_offset_ff};
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_res
            wire [7:0] pos_b = pos_ext[gi*8 +: 8];
            wire [7:0] acc_b = gi == 0 ? {5'h00, access_level_ff} : 8'h00;
            wire [7:0] dsc_b = gi == 0 ? desc : 8'h00;
            assign res_byte[gi] = !is_ind ? dsc_b : is_pos ? pos_b : acc_b;
            always_ff @(posedge ref_clk) begin
                if (clr) begin
                    buf_ff[gi] <= 8'h00;
                end else if (host_wr & (lnk.addr == REG_BUF0 + 4'(gi))) begin
                    buf_ff[gi] <= lnk.wdata;
                end else if (exec & is_rd & !refuse) begin
                    buf_ff[gi] <= res_byte[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            addh_ff <= 8'h00;
            addl_ff <= 8'h00;
            offh_ff <= 8'h00;
            offl_ff <= 8'h00;
        end else if (host_wr) begin
            addh_ff <= lnk.addr == REG_ADDH ? lnk.wdata : addh_ff;
            addl_ff <= lnk.addr == REG_ADDL ? lnk.wdata : addl_ff;
            offh_ff <= lnk.addr == REG_OFFH ? lnk.wdata : offh_ff;
            offl_ff <= lnk.addr == REG_OFFL ? lnk.wdata : offl_ff;
        end
    end

    // Release flag: cleared on start, set when the result stands
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            rel_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (start) begin
            rel_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (exec & !(do_save & !bad_sel)) begin
            rel_ff <= 1'b1;
            err_ff <= refuse | acc_bad | bad_sel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clr) begin
            state_ff <= ST_IDLE;
            shut_sel_ff <= 1'b0;
            save_req_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (do_save) begin
                shut_sel_ff <= offset == OFF_SHUT;
            end
            save_req_ff <= (do_save & !bad_sel) | (save_req_ff & !save_done);
        end
    end

    // Level back to public after any reset
    always_ff @(posedge ref_clk) begin
        if (clr) begin
            access_level_ff <= LVL_PUBLIC;
        end else if (do_acc) begin
            // Only a valid request changes it; bad key keeps it
            access_level_ff <= req_lvl[2:0];
        end
    end

    // Offset survives a soft reset; nonvolatile restore is outside this block
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pos_offset_ff <= '0;
            pos_preset_ff <= 1'b0;
            proto_reset_ff <= 1'b0;
            shut_down_ff <= 1'b0;
        end else begin
            // New value minus raw shaft position
            if (do_pos) begin
                pos_offset_ff <= pos_val - raw_pos;
            end
            pos_preset_ff <= do_pos;
            proto_reset_ff <= do_pos;
            shut_down_ff <= shut_down_ff | (nxt_state == ST_DEAD);
        end
    end

    wire [7:0] stat = {5'h00, shut_down_ff, err_ff, rel_ff};
    wire [7:0] rd_mux = lnk.addr < REG_ADDH ? buf_ff[lnk.addr[2:0]] :
        lnk.addr == REG_ADDH ? addh_ff : lnk.addr == REG_ADDL ? addl_ff :
        lnk.addr == REG_OFFH ? offh_ff : lnk.addr == REG_OFFL ? offl_ff :
        lnk.addr == REG_STAT ? stat : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= (lnk.rd & (state_ff != ST_DEAD)) ? rd_mux : 8'h00;
        end
    end
    assign lnk.rdata = rdata_ff;
endmodule : ear_encoder

// *** hw/ear_if.sv ***
// Parameters-channel register link between drive master and encoder.
// Assumes one shared clock; read data stand the cycle after the read strobe.
`timescale 1ns/1ps
interface ear_if;
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport enc (input wr, input rd, input addr, input wdata, output rdata);
    modport drv (output wr, output rd, output addr, output wdata, input rdata);
endinterface : ear_if

// *** hw/ear_master.sv ***
// Drive-side master: software loads a transaction, master runs it over the link.
// Assumes software uses the plain strobe port and one shared clock.
`timescale 1ns/1ps
module ear_master #(
    parameter int WAIT_CYC = ear_pkg::RST_WAIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    ear_if.drv lnk,
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata_ff
);
    import ear_pkg::*;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_LOAD = 3'b001,
        M_PREQ = 3'b010,
        M_PGAP = 3'b011,
        M_PCHK = 3'b100,
        M_WAIT = 3'b101,
        M_FETCH = 3'b110
    } ear_m_st_t;

    ear_m_st_t state_ff;
    logic [7:0] req_ff [0:11];
    logic [7:0] rsp_ff [0:7];
    logic [3:0] cnt_ff;
    logic [1:0] ph_ff;
    logic [31:0] wait_ff;
    logic busy_ff, done_ff, err_ff;
    logic wr_ff, rd_ff;
    logic [3:0] addr_ff;
    logic [7:0] wdata_ff;

    wire sw_start = sw_wr & (sw_addr == REG_CTRL) & (sw_wdata == CTRL_START) & !busy_ff;
    wire sw_req = sw_wr & (sw_addr < REG_CTRL) & !busy_ff;
    wire [9:0] res_idx = {req_ff[REG_ADDH][1:0], req_ff[REG_ADDL]};
    wire is_rd = req_ff[REG_ADDH][ADDH_RD_BIT];
    // Reset or shut-down gets no report: wait a fixed time instead
    wire no_rep = !is_rd & req_ff[REG_ADDH][ADDH_IND_BIT] & (res_idx == RES_RESET);
    wire [7:0] ld_data = cnt_ff == REG_CTRL ? CTRL_START : req_ff[cnt_ff];
    wire rel = lnk.rdata[ST_REL_BIT];

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            for (int i = 0; i < 12; i++) begin
                req_ff[i] <= 8'h00;
            end
        end else if (sw_req) begin
            req_ff[sw_addr] <= sw_wdata;
        end
    end

    // Load, start, poll release flag, fetch result
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_ff <= M_IDLE;
            cnt_ff <= 4'h0;
            ph_ff <= 2'h0;
            wait_ff <= 32'h0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 4'h0;
            wdata_ff <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                rsp_ff[i] <= 8'h00;
            end
        end else begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            unique case (state_ff)
                M_IDLE: begin
                    if (sw_start) begin
                        busy_ff <= 1'b1;
                        done_ff <= 1'b0;
                        err_ff <= 1'b0;
                        cnt_ff <= 4'h0;
                        state_ff <= M_LOAD;
                    end
                end
                M_LOAD: begin
                    wr_ff <= 1'b1;
                    addr_ff <= cnt_ff;
                    wdata_ff <= ld_data;
                    cnt_ff <= cnt_ff + 4'h1;
                    if (cnt_ff == REG_CTRL) begin
                        wait_ff <= 32'h0;
                        state_ff <= no_rep ? M_WAIT : M_PREQ;
                    end
                end
                M_WAIT: begin
                    wait_ff <= wait_ff + 32'h1;
                    if (wait_ff == 32'(WAIT_CYC - 1)) begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                        state_ff <= M_IDLE;
                    end
                end
                M_PREQ: begin
                    rd_ff <= 1'b1;
                    addr_ff <= REG_STAT;
                    state_ff <= M_PGAP;
                end
                M_PGAP: begin
                    state_ff <= M_PCHK;
                end
                M_PCHK: begin
                    if (rel) begin
                        err_ff <= lnk.rdata[ST_ERR_BIT];
                        cnt_ff <= 4'h0;
                        ph_ff <= 2'h0;
                        state_ff <= M_FETCH;
                    end else begin
                        state_ff <= M_PREQ;
                    end
                end
                M_FETCH: begin
                    // Three cycles a byte: strobe, device registers, capture
                    ph_ff <= ph_ff == 2'h2 ? 2'h0 : ph_ff + 2'h1;
                    if (ph_ff == 2'h0) begin
                        rd_ff <= 1'b1;
                        addr_ff <= cnt_ff;
                    end
                    if (ph_ff == 2'h2) begin
                        rsp_ff[cnt_ff[2:0]] <= lnk.rdata;
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'h7) begin
                            busy_ff <= 1'b0;
                            done_ff <= 1'b1;
                            state_ff <= M_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= M_IDLE;
                end
            endcase
        end
    end

    wire [7:0] stat = {5'h00, err_ff, done_ff, busy_ff};
    wire [7:0] sw_mux = sw_addr < REG_ADDH ? rsp_ff[sw_addr[2:0]] :
        sw_addr < REG_CTRL ? req_ff[sw_addr] : sw_addr == REG_STAT ? stat : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sw_rdata_ff <= 8'h00;
        end else begin
            sw_rdata_ff <= sw_rd ? sw_mux : 8'h00;
        end
    end

    assign lnk.wr = wr_ff;
    assign lnk.rd = rd_ff;
    assign lnk.addr = addr_ff;
    assign lnk.wdata = wdata_ff;
endmodule : ear_master

// *** hw/ear_pkg.sv ***
// Shared constants for the encoder administration resources and the drive-side master.
// Assumes both ends run on one 200 MHz clock with a synchronous active-low reset.
package ear_pkg;
    // Link register indexes: payload bytes sit at 0 to 7
    localparam logic [3:0] REG_BUF0 = 4'h0;
    localparam logic [3:0] REG_ADDH = 4'h8;
    localparam logic [3:0] REG_ADDL = 4'h9;
    localparam logic [3:0] REG_OFFH = 4'hA;
    localparam logic [3:0] REG_OFFL = 4'hB;
    localparam logic [3:0] REG_CTRL = 4'hC;
    localparam logic [3:0] REG_STAT = 4'hD;
    // Address-high byte fields
    localparam int ADDH_RD_BIT = 6;
    localparam int ADDH_IND_BIT = 4;
    localparam logic [7:0] CTRL_START = 8'h01;
    // Status bits
    localparam int ST_REL_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_SHUT_BIT = 2;
    // Resource indexes
    localparam logic [9:0] RES_RESET = 10'h100;
    localparam logic [9:0] RES_SHAFT_POSITION_PRESET = 10'h101;
    localparam logic [9:0] RES_ACCESS = 10'h104;
    // Reset offset selection
    localparam logic [15:0] OFF_RESET = 16'h0000;
    localparam logic [15:0] OFF_SHUT = 16'h0001;
    // Descriptor fields
    localparam logic [15:0] DSC_SIZE = 16'h0001;
    localparam logic [15:0] DSC_RDLVL = 16'h0002;
    localparam logic [15:0] DSC_WRLVL = 16'h0003;
    localparam logic [15:0] DSC_OVR = 16'h0004;
    localparam logic [15:0] DSC_TYPE = 16'h0005;
    localparam logic [7:0] RST_SIZE = 8'h00;
    localparam logic [7:0] RST_RDLVL = 8'h0F;
    localparam logic [7:0] RST_WRLVL = 8'h00;
    localparam logic [7:0] RST_OVR = 8'h96;
    localparam logic [7:0] RST_TYPE = 8'h01;
    localparam logic [7:0] POS_SIZE = 8'h08;
    localparam logic [7:0] POS_RDLVL = 8'h00;
    localparam logic [7:0] POS_WRLVL = 8'h02;
    localparam logic [7:0] POS_OVR = 8'h64;
    localparam logic [7:0] POS_TYPE = 8'h06;
    localparam logic [7:0] ACC_SIZE = 8'h08;
    localparam logic [7:0] ACC_RDLVL = 8'h00;
    localparam logic [7:0] ACC_WRLVL = 8'h00;
    localparam logic [7:0] ACC_OVR = 8'h46;
    localparam logic [7:0] ACC_TYPE = 8'h18;
    // Access levels and default keys
    localparam logic [2:0] LVL_PUBLIC = 3'h0;
    localparam logic [7:0] LVL_MAX = 8'h04;
    localparam logic [7:0] KEY_DIGIT0 = 8'h30;
    localparam int POS_W = 40;
    // Reset recovery wait: init time plus maximum time overrun
    localparam int ENC_INIT_MS = 100;
    localparam int RST_OVR_MS = 150;
    localparam int CLK_KHZ = 200000;
    localparam int RST_WAIT_CYC = (ENC_INIT_MS + RST_OVR_MS) * CLK_KHZ;
endpackage : ear_pkg

// *** tb/ear_properties.sv ***
// Concurrent checks on the link between the master and encoder ends.
// Assumes one clock; instantiated by tb_top beside the link interface.
`timescale 1ns/1ps
module ear_checker (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wr,
    input wire logic rd,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic save_req_ff,
    input wire logic save_done,
    input wire logic pos_preset_ff,
    input wire logic proto_reset_ff,
    input wire logic shut_down_ff,
    input wire logic [2:0] access_level_ff
);
    import ear_pkg::*;
    logic [3:0] since_ctrl_ff;
    logic [3:0] nxt_since_ctrl;
    wire start_w = wr && addr == REG_CTRL && wdata == CTRL_START;
    // Saturates so that a long idle spell never wraps back to a small count
    assign nxt_since_ctrl = start_w ? 4'h0 : since_ctrl_ff + {3'h0, since_ctrl_ff != 4'hF};
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            since_ctrl_ff <= 4'hF;
        end else begin
            since_ctrl_ff <= nxt_since_ctrl;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_strobe_excl; !(wr && rd); endproperty
    a_strobe_excl: assert property (p_strobe_excl) else $error("strobes overlap");
    property p_rdata_idle; !$past(rd) |-> rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    property p_dead_quiet; shut_down_ff && $past(shut_down_ff) |-> rdata == 8'h00; endproperty
    a_dead_quiet: assert property (p_dead_quiet) else $error("answer after stop");
    property p_shut_sticky; shut_down_ff |=> shut_down_ff; endproperty
    a_shut_sticky: assert property (p_shut_sticky) else $error("stop state left");
    property p_save_hold; save_req_ff && !save_done |=> save_req_ff; endproperty
    a_save_hold: assert property (p_save_hold) else $error("save dropped early");
    property p_save_first; $rose(shut_down_ff) |-> $past(save_req_ff) || $past(save_req_ff, 2);
    endproperty
    a_save_first: assert property (p_save_first) else $error("stop without save");
    property p_preset_proto; pos_preset_ff |-> proto_reset_ff ##1 !pos_preset_ff; endproperty
    a_preset_proto: assert property (p_preset_proto) else $error("preset pulse bad");
    property p_preset_cause; pos_preset_ff |-> since_ctrl_ff < 4'h6; endproperty
    a_preset_cause: assert property (p_preset_cause) else $error("preset unasked");
    property p_level_range; access_level_ff <= 3'h4; endproperty
    a_level_range: assert property (p_level_range) else $error("level too high");
    property p_level_hold; $changed(access_level_ff) && access_level_ff != 3'h0
        |-> since_ctrl_ff < 4'h6; endproperty
    a_level_hold: assert property (p_level_hold) else $error("level changed alone");
endmodule : ear_checker

// *** tb/tb_top.sv ***
// Self-checking bench: master and encoder ends joined by the link.
// Assumes the software port is driven by this bench on rising edges.
`timescale 1ns/1ps
module tb_top;
    import ear_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [7:0] sw_rdata_ff;
    // Shaft held still: raw position never moves
    logic [39:0] raw_pos = 40'h00_0000_1234;
    logic save_done = 1'b0;
    logic save_req_ff, pos_preset_ff, proto_reset_ff, shut_down_ff;
    logic [39:0] pos_offset_ff;
    logic [2:0] access_level_ff;
    logic [7:0] st, d;
    logic [39:0] v;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_saves = 0;
    int n_presets = 0;
    ear_if lnk ();
    ear_encoder i_ear_encoder (.ref_clk(ref_clk), .rstn(rstn), .lnk(lnk), .raw_pos(raw_pos),
        .save_done(save_done), .save_req_ff(save_req_ff), .pos_preset_ff(pos_preset_ff),
        .pos_offset_ff(pos_offset_ff), .proto_reset_ff(proto_reset_ff),
        .shut_down_ff(shut_down_ff), .access_level_ff(access_level_ff));
    // Recovery wait shortened so a reset command waits 50 cycles after it is loaded
    ear_master #(.WAIT_CYC(50)) i_ear_master (.ref_clk(ref_clk), .rstn(rstn), .lnk(lnk),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata_ff(sw_rdata_ff));
    ear_checker i_ear_checker (.ref_clk(ref_clk), .rstn(rstn), .wr(lnk.wr), .rd(lnk.rd),
        .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .save_req_ff(save_req_ff),
        .save_done(save_done), .pos_preset_ff(pos_preset_ff), .proto_reset_ff(proto_reset_ff),
        .shut_down_ff(shut_down_ff), .access_level_ff(access_level_ff));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Persistent store acknowledges one cycle after each request
    always @(posedge ref_clk) begin
        save_done <= save_req_ff;
        n_saves += int'(save_req_ff && !save_done);
        n_presets += int'(pos_preset_ff);
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
    endtask : do_reset
    task automatic sw_write(input logic [3:0] a, input logic [7:0] w);
        @(posedge ref_clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= w;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask : sw_write
    task automatic sw_read(input logic [3:0] a, output logic [7:0] r);
        @(posedge ref_clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        #1 r = sw_rdata_ff;
    endtask : sw_read
    // Loads one request, starts it and polls the done bit a bounded number of times
    task automatic txn(input logic [7:0] ah, input logic [7:0] al, input logic [7:0] ol,
        input logic [63:0] pl);
        for (int i = 0; i < 8; i++) sw_write(REG_BUF0 + 4'(i), pl[8*i +: 8]);
        sw_write(REG_ADDH, ah);
        sw_write(REG_ADDL, al);
        sw_write(REG_OFFH, 8'h00);
        sw_write(REG_OFFL, ol);
        sw_write(REG_CTRL, CTRL_START);
        st = 8'h00;
        for (int i = 0; i < 200 && st[1] !== 1'b1; i++) sw_read(REG_STAT, st);
    endtask : txn
    task automatic set_lvl(input logic [7:0] l, input logic [7:0] ol);
        txn(8'h11, RES_ACCESS[7:0], ol, {{4{KEY_DIGIT0 + l}}, 24'h0, l});
    endtask : set_lvl
    task automatic t_desc();
        logic [9:0] res [3] = '{RES_RESET, RES_SHAFT_POSITION_PRESET, RES_ACCESS};
        logic [7:0] e [15] = '{RST_SIZE, RST_RDLVL, RST_WRLVL, RST_OVR, RST_TYPE,
            POS_SIZE, POS_RDLVL, POS_WRLVL, POS_OVR, POS_TYPE,
            ACC_SIZE, ACC_RDLVL, ACC_WRLVL, ACC_OVR, ACC_TYPE};
        for (int r = 0; r < 3; r++) begin
            for (int f = 0; f < 5; f++) begin
                txn({6'h10, res[r][9:8]}, res[r][7:0], 8'(f + 1), 64'h0);
                sw_read(REG_BUF0, d);
                chk(d, e[r*5+f]); // descriptor byte
            end
        end
    endtask : t_desc
    task automatic t_access();
        txn(8'h51, 8'h04, 8'h00, 64'h0);
        sw_read(REG_BUF0, d);
        chk(d, 0); // level read
        txn(8'h11, 8'h04, 8'h00, {32'h31313131, 32'h02});
        chk({st[2], access_level_ff}, 4'h8); // wrong key
        for (int l = 1; l < 5; l++) begin
            set_lvl(8'(l), 8'h00);
            chk({st[2], access_level_ff}, l); // default key
        end
        txn(8'h51, 8'h04, 8'h00, 64'h0);
        sw_read(REG_BUF0, d);
        chk(d, 4); // level read
        set_lvl(8'h05, 8'h00);
        chk({st[2], access_level_ff}, 4'hC); // level above four
        set_lvl(8'h01, 8'h01);
        chk({st[2], access_level_ff}, 4'hC); // nonzero offset
    endtask : t_access
    task automatic t_pos();
        set_lvl(8'h01, 8'h00);
        txn(8'h11, 8'h01, 8'h00, 64'h12_3456_789A);
        chk({st[2], n_presets[3:0], pos_offset_ff}, {5'h10, 40'h0}); // refused
        set_lvl(8'h02, 8'h00);
        txn(8'h11, 8'h01, 8'h00, 64'h12_3456_789A); // in-range value
        chk({st[2], n_presets[3:0]}, 5'h01); // one preset
        chk(pos_offset_ff, 40'h12_3456_789A - raw_pos); // offset applied
        txn(8'h51, 8'h01, 8'h00, 64'h0);
        for (int i = 0; i < 5; i++) sw_read(REG_BUF0 + 4'(i), v[8*i +: 8]);
        chk(v, 40'h12_3456_789A - raw_pos); // offset read
    endtask : t_pos
    task automatic t_reset_cmd();
        // Reset writes are not polled, so a bad offset shows as no save and no stop
        txn(8'h11, 8'h00, 8'h02, 64'h0);
        chk({st[2], st[1], n_saves[3:0], shut_down_ff}, 7'h20); // bad offset
        txn(8'h51, 8'h00, 8'h00, 64'h0);
        chk(st[2], 1); // level 15 read
        set_lvl(8'h03, 8'h00);
        txn(8'h11, 8'h00, 8'h00, 64'h0);
        chk({st[1], n_saves[3:0], access_level_ff, shut_down_ff}, 9'h110); // soft reset
        txn(8'h11, 8'h00, 8'h01, 64'h0);
        chk({n_saves[3:0], shut_down_ff}, 5'h5); // saved then stop
        set_lvl(8'h01, 8'h00);
        chk({st[1], access_level_ff}, 0); // ignored
        do_reset();
        @(posedge ref_clk);
        chk({shut_down_ff, access_level_ff}, 0); // power cycle
    endtask : t_reset_cmd
    initial begin
        do_reset();
        @(posedge ref_clk);
        chk({shut_down_ff, access_level_ff, pos_offset_ff}, 0); // after reset
        t_desc();
        t_access();
        t_pos();
        t_reset_cmd();
        complete_run();
    end
endmodule : tb_top
